// File: core/rbb_busy_bcast_ctrl.sv
/*
 * remote-terminal busy / broadcast decision logic: per addressed command it
 * decides broadcast recognition, the status busy bit, and whether data words
 * are stored or transmitted. configuration words sit behind a plain register
 * port; the busy lookup table is read from shared ram over a read-only port.
 * assumes: command words arrive as one-cycle strobes from decoder logic on
 * the same clock; ram answers a read with ram_rvalid_i some cycles later.
 */
// Function
// - non-enhanced, broadcast-off clear: address 31 is broadcast.
// - broadcast-off set: address 31 is an ordinary discrete address.
// - broadcast then contiguous own transmit: drop broadcast, answer transmit.
// - busy control bit low forces busy on every command unless enhanced with alternate status selected.
// - alternate status option: busy comes straight from alternate busy bit.
// - busy non-mode receive stores data unless enhanced with receive-suppress set.
// - busy non-mode transmit: status only, no data words.
// - table lookup only enhanced, alternate off, lookup enabled.
// - table is eight ram words, picked by broadcast, direction, subaddress msb.
// - subaddress bits 3..0 pick the busy bit; one means busy.
// - busy vector word withheld unless enhanced and mode override set.
// - busy sync-with-data stored; with suppress only if enhanced and override.
// - busy bit word sent unless enhanced and inhibit-bit-word set.
// - enhanced busy is the or of the three source terms.
// - table address is base plus broadcast, transmit, subaddress msb offset.
`timescale 1ns/10ps
module rbb_busy_bcast_ctrl (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rstn_i,
    // register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic [15:0]               reg_rdata_o,
    // command side
    input  wire logic                 cmd_valid_i,
    input  wire rbb_pkg::rbb_cmd_t    cmd_word_i,
    input  wire logic                 cmd_contig_i,
    input  wire logic [4:0]           own_rt_addr_i,
    // shared ram read port
    output logic                      ram_rd_o,
    output logic [15:0]               ram_addr_o,
    input  wire logic [15:0]          ram_rdata_i,
    input  wire logic                 ram_rvalid_i,
    // decision output
    output logic                      resp_valid_o,
    output rbb_pkg::rbb_dec_t         resp_o,
    output logic                      superseded_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    rbb_pkg::rbb_st_t  s_q;
    rbb_pkg::rbb_st_t  s_d;
    rbb_pkg::rbb_cfg_t cfg;
    logic              rst_n;
    logic              in_bcast;
    logic              in_own;
    logic [15:0]       lut_addr;
    logic              lut_hit;

    ////////////////////////////////////////////////////////////////////////
    // reset release and table helper
    rbb_rst_sync u_rst (
        .clk_i  (ref_clk_i),
        .rstn_i (rstn_i),
        .rstn_o (rst_n)
    );

    // address from the incoming command, bit from the stored one
    rbb_lut_sel u_lut (
        .bcast_i  (in_bcast),
        .tx_i     (cmd_word_i.tx),
        .sa_msb_i (cmd_word_i.sa[4]),
        .word_i   (ram_rdata_i),
        .sa_lo_i  (s_q.cmd.sa[3:0]),
        .addr_o   (lut_addr),
        .hit_o    (lut_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // configuration view and address recognition
    assign cfg = rbb_pkg::cfg_of(s_q.cfg1, s_q.cfg2, s_q.cfg3, s_q.cfg4, s_q.cfg5);

    // address 31 is broadcast unless broadcast-off makes it a discrete one
    assign in_bcast = (cmd_word_i.rt_addr == rbb_pkg::BCAST_ADDR) && !cfg.bcast_off;
    assign in_own   = (cmd_word_i.rt_addr == own_rt_addr_i) && !in_bcast;

    ////////////////////////////////////////////////////////////////////////
    // busy source terms; enhanced off means alternate status is not selected
    function automatic logic busy_of(input rbb_pkg::rbb_cfg_t c, input logic hit);
        logic alt;
        logic b;
        alt = c.enh && c.alt_status_sel;
        b   = 1'b0;
        if (!c.busy_n && !alt) begin
            b = 1'b1;
        end
        if (alt && c.alt_status_busy_bit) begin
            b = 1'b1;
        end
        if (rbb_pkg::lut_applies(c) && hit) begin
            b = 1'b1;
        end
        return b;
    endfunction

    // full decision for one command; hit is the looked-up table bit
    function automatic rbb_pkg::rbb_dec_t decide(input rbb_pkg::rbb_cfg_t c,
                                                 input rbb_pkg::rbb_cmd_t cmd,
                                                 input logic bc,
                                                 input logic hit);
        rbb_pkg::rbb_dec_t d;
        logic mode;
        logic sup;
        logic ovr;
        mode      = rbb_pkg::is_mode(cmd.sa);
        sup       = c.enh && c.rx_sup;
        ovr       = c.enh && c.modecmd_busy_override;
        d.bcast   = bc;
        d.busy    = busy_of(c, hit);
        d.store   = 1'b0;
        d.tx_data = 1'b0;
        if (!cmd.tx) begin
            if (!d.busy || !sup) begin
                d.store = 1'b1;
            end else if (mode && cmd.wcmc != rbb_pkg::MC_SYNC_DAT) begin
                d.store = 1'b1;
            end else if (mode && ovr) begin
                d.store = 1'b1;
            end
        end else if (!d.busy) begin
            d.tx_data = 1'b1;
        end else if (!mode) begin
            d.tx_data = 1'b0;
        end else if (cmd.wcmc == rbb_pkg::MC_TX_VEC) begin
            d.tx_data = ovr;
        end else if (cmd.wcmc == rbb_pkg::MC_TX_BIT) begin
            d.tx_data = !(c.enh && c.inh_bit);
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        s_d            = s_q;
        s_d.resp_valid = 1'b0;
        s_d.supersede  = 1'b0;
        s_d.rdata      = 16'h0000;

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                rbb_pkg::CFG1_OFS: begin
                    s_d.cfg1 = reg_wdata_i;
                end
                rbb_pkg::CFG2_OFS: begin
                    s_d.cfg2 = reg_wdata_i;
                end
                rbb_pkg::CFG3_OFS: begin
                    s_d.cfg3 = reg_wdata_i;
                end
                rbb_pkg::CFG4_OFS: begin
                    s_d.cfg4 = reg_wdata_i;
                end
                rbb_pkg::CFG5_OFS: begin
                    s_d.cfg5 = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end

        // register reads, data stand in the next cycle only
        if (reg_rd_i) begin
            case (reg_addr_i)
                rbb_pkg::CFG1_OFS: begin
                    s_d.rdata = s_q.cfg1;
                end
                rbb_pkg::CFG2_OFS: begin
                    s_d.rdata = s_q.cfg2;
                end
                rbb_pkg::CFG3_OFS: begin
                    s_d.rdata = s_q.cfg3;
                end
                rbb_pkg::CFG4_OFS: begin
                    s_d.rdata = s_q.cfg4;
                end
                rbb_pkg::CFG5_OFS: begin
                    s_d.rdata = s_q.cfg5;
                end
                rbb_pkg::STAT_OFS: begin
                    s_d.rdata = {s_q.resp_cnt, 2'h0, s_q.state, s_q.dec};
                end
                default: begin
                    s_d.rdata = 16'h0000;
                end
            endcase
        end

        // lookup sequencing
        case (s_q.state)
            rbb_pkg::ST_IDLE: begin
            end
            rbb_pkg::ST_FETCH: begin
                s_d.state = rbb_pkg::ST_WAIT; // single read per command
            end
            rbb_pkg::ST_WAIT: begin
                if (ram_rvalid_i) begin
                    s_d.dec        = decide(cfg, s_q.cmd, s_q.bcast, lut_hit);
                    s_d.resp_valid = 1'b1;
                    s_d.resp_cnt   = s_q.resp_cnt + 8'h01;
                    s_d.state      = rbb_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.state = rbb_pkg::ST_IDLE;
            end
        endcase

        // a new command restarts the sequence, even mid-lookup
        if (cmd_valid_i) begin
            s_d.prev_bcast = 1'b0;
            if (in_bcast || in_own) begin
                s_d.cmd        = cmd_word_i;
                s_d.bcast      = in_bcast;
                s_d.prev_bcast = in_bcast;
                // contiguous own transmit after broadcast cancels the broadcast
                s_d.supersede  = s_q.prev_bcast && cmd_contig_i
                                 && in_own && cmd_word_i.tx;
                if (rbb_pkg::lut_applies(cfg)) begin
                    s_d.ram_addr = lut_addr;
                    s_d.state    = rbb_pkg::ST_FETCH;
                end else begin
                    s_d.dec        = decide(cfg, cmd_word_i, in_bcast, 1'b0);
                    s_d.resp_valid = 1'b1;
                    s_d.resp_cnt   = s_q.resp_cnt + 8'h01;
                    s_d.state      = rbb_pkg::ST_IDLE;
                end
            end else begin
                s_d.state = rbb_pkg::ST_IDLE; // not for us: nothing to decide
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q            <= '0;
            s_q.state      <= rbb_pkg::ST_IDLE;
            s_q.ram_addr   <= rbb_pkg::LUT_BASE;
            s_q.cfg1       <= rbb_pkg::CFG1_RST;
            s_q.cfg2       <= rbb_pkg::CFG2_RST;
            s_q.cfg3       <= rbb_pkg::CFG3_RST;
            s_q.cfg4       <= rbb_pkg::CFG4_RST;
            s_q.cfg5       <= rbb_pkg::CFG5_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; the ram port is read-only, the table is never written
    assign ram_rd_o     = (s_q.state == rbb_pkg::ST_FETCH);
    assign ram_addr_o   = s_q.ram_addr;
    assign reg_rdata_o  = s_q.rdata;
    assign resp_valid_o = s_q.resp_valid;
    assign resp_o       = s_q.dec;
    assign superseded_o = s_q.supersede;

endmodule

// File: core/rbb_lut_sel.sv
/*
 * busy lookup table address former and bit picker.
 * assumes: address side and bit side may belong to different commands.
 */
`timescale 1ns/10ps
module rbb_lut_sel (
    input  wire logic        bcast_i,
    input  wire logic        tx_i,
    input  wire logic        sa_msb_i,
    input  wire logic [15:0] word_i,
    input  wire logic [3:0]  sa_lo_i,
    output logic [15:0]      addr_o,
    output logic             hit_o
);

    // offset bit 2 broadcast, bit 1 transmit, bit 0 subaddress msb
    assign addr_o = rbb_pkg::LUT_BASE + {13'h0000, bcast_i, tx_i, sa_msb_i};

    // low subaddress bits pick one of the sixteen busy bits
    assign hit_o = word_i[sa_lo_i];

endmodule

// File: core/rbb_pkg.sv
/*
 * shared constants, carrier structs and decision functions for the
 * remote-terminal busy / broadcast decision block.
 * assumes: 16-bit configuration words, 16-bit shared-ram words.
 */
package rbb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets on the plain register port
    localparam logic [7:0] CFG1_OFS = 8'h00;
    localparam logic [7:0] CFG2_OFS = 8'h04;
    localparam logic [7:0] CFG3_OFS = 8'h08;
    localparam logic [7:0] CFG4_OFS = 8'h0C;
    localparam logic [7:0] CFG5_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;

    // field positions inside the configuration words
    localparam int CFG1_BUSY_N_POS   = 10;
    localparam int CFG1_ALT_BUSY_POS = 4;
    localparam int CFG2_LUT_EN_POS   = 13;
    localparam int CFG3_ENH_POS      = 15;
    localparam int CFG3_MC_OVR_POS   = 13;
    localparam int CFG3_ALT_SEL_POS  = 5;
    localparam int CFG3_RX_SUP_POS   = 3;
    localparam int CFG4_INH_BIT_POS  = 14;
    localparam int CFG5_BC_OFF_POS   = 7;

    // reset values: busy control line idles high (not busy)
    localparam logic [15:0] CFG1_RST = 16'h0400;
    localparam logic [15:0] CFG2_RST = 16'h0000;
    localparam logic [15:0] CFG3_RST = 16'h0000;
    localparam logic [15:0] CFG4_RST = 16'h0000;
    localparam logic [15:0] CFG5_RST = 16'h0000;

    // busy lookup table and command encodings
    localparam logic [15:0] LUT_BASE    = 16'h0240;
    localparam logic [4:0]  BCAST_ADDR  = 5'h1F;
    localparam logic [4:0]  SA_MODE_LO  = 5'h00;
    localparam logic [4:0]  SA_MODE_HI  = 5'h1F;
    localparam logic [4:0]  MC_TX_VEC   = 5'h10;
    localparam logic [4:0]  MC_SYNC_DAT = 5'h11;
    localparam logic [4:0]  MC_TX_BIT   = 5'h13;

    ////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic [4:0] rt_addr;
        logic       tx;
        logic [4:0] sa;
        logic [4:0] wcmc;
    } rbb_cmd_t;

    typedef struct packed {
        logic enh;
        logic alt_status_sel;
        logic busy_n;
        logic alt_status_busy_bit;
        logic lut_en;
        logic rx_sup;
        logic modecmd_busy_override;
        logic inh_bit;
        logic bcast_off;
    } rbb_cfg_t;

    typedef struct packed {
        logic busy;
        logic store;
        logic tx_data;
        logic bcast;
    } rbb_dec_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT  = 2'b10,
        ST_SPARE = 2'b11
    } rbb_state_t;

    typedef struct packed {
        rbb_state_t  state;
        rbb_cmd_t    cmd;
        logic        bcast;
        logic        prev_bcast;
        rbb_dec_t    dec;
        logic        resp_valid;
        logic        supersede;
        logic [15:0] ram_addr;
        logic [15:0] rdata;
        logic [15:0] cfg1;
        logic [15:0] cfg2;
        logic [15:0] cfg3;
        logic [15:0] cfg4;
        logic [15:0] cfg5;
        logic [7:0]  resp_cnt;
    } rbb_st_t;

    ////////////////////////////////////////////////////////////////////////
    // decision functions
    function automatic rbb_cfg_t cfg_of(input logic [15:0] c1, input logic [15:0] c2,
                                        input logic [15:0] c3, input logic [15:0] c4,
                                        input logic [15:0] c5);
        rbb_cfg_t c;
        c.enh                   = c3[CFG3_ENH_POS];
        c.alt_status_sel        = c3[CFG3_ALT_SEL_POS];
        c.busy_n                = c1[CFG1_BUSY_N_POS];
        c.alt_status_busy_bit   = c1[CFG1_ALT_BUSY_POS];
        c.lut_en                = c2[CFG2_LUT_EN_POS];
        c.rx_sup                = c3[CFG3_RX_SUP_POS];
        c.modecmd_busy_override = c3[CFG3_MC_OVR_POS];
        c.inh_bit               = c4[CFG4_INH_BIT_POS];
        c.bcast_off             = c5[CFG5_BC_OFF_POS];
        return c;
    endfunction

    function automatic logic is_mode(input logic [4:0] sa);
        return (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
    endfunction

    // table lookup only counts in enhanced mode with alternate status off
    function automatic logic lut_applies(input rbb_cfg_t c);
        return c.enh && !c.alt_status_sel && c.lut_en;
    endfunction

endpackage

// File: core/rbb_rst_sync.sv
/*
 * reset release synchroniser: asserts at once, releases after two edges.
 * assumes: rstn_i is asynchronous to clk_i.
 */
`timescale 1ns/10ps
module rbb_rst_sync (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    output logic      rstn_o
);

    logic [1:0] stage_q;

    // two flops so the release edge cannot go metastable into the core
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage_q <= 2'h0;
        end else begin
            stage_q <= {stage_q[0], 1'b1};
        end
    end

    assign rstn_o = stage_q[1];

endmodule

// File: verif/rbb_assertions.sv
/*
 * port checker for the busy / broadcast decision block.
 * assumes: bound into the top module; one clock, reset active low.
 */
`timescale 1ns/10ps
module rbb_chk (
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic              cmd_valid_i,
    input wire rbb_pkg::rbb_cmd_t cmd_word_i,
    input wire logic              cmd_contig_i,
    input wire logic [4:0]        own_rt_addr_i,
    input wire logic              ram_rd_o,
    input wire logic [15:0]       ram_addr_o,
    input wire logic [15:0]       ram_rdata_i,
    input wire logic              ram_rvalid_i,
    input wire logic              resp_valid_o,
    input wire rbb_pkg::rbb_dec_t resp_o,
    input wire logic              superseded_o
);
    rbb_pkg::rbb_cmd_t lst_q;
    logic              own_tx_q;
    logic              wait_q;
    logic              hit_q;

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    ////////////////////////////////////////////////////////////////////////
    // last command, pending fetch, returned table bit
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {lst_q, own_tx_q, wait_q, hit_q} <= '0;
        end else begin
            if (cmd_valid_i) lst_q <= cmd_word_i;
            own_tx_q <= cmd_valid_i && cmd_contig_i && cmd_word_i.tx
                        && (cmd_word_i.rt_addr == own_rt_addr_i);
            if (cmd_valid_i || resp_valid_o) wait_q <= 1'b0;
            else if (ram_rd_o) wait_q <= 1'b1;
            if (ram_rvalid_i) hit_q <= ram_rdata_i[lst_q.sa[3:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_rd_one_cycle: assert property (ram_rd_o |=> !ram_rd_o)
        else $error("table read over one cycle");
    a_rd_after_cmd: assert property (
        ram_rd_o |-> $past(cmd_valid_i) || $past(cmd_valid_i, 2))
        else $error("read without command");
    a_lut_addr_form: assert property (ram_rd_o |-> ram_addr_o[15:3] == 13'h0048
        && ram_addr_o[1:0] == {lst_q.tx, lst_q.sa[4]}
        && (!ram_addr_o[2] || lst_q.rt_addr == 5'h1F))
        else $error("bad table address");
    a_resp_after_fetch: assert property (
        ram_rvalid_i && wait_q && !cmd_valid_i |=> resp_valid_o)
        else $error("no decision after fetch");
    a_resp_has_cause: assert property (
        resp_valid_o |-> $past(cmd_valid_i) || $past(ram_rvalid_i))
        else $error("decision uncaused");
    a_table_hit_busy: assert property (
        resp_valid_o && $past(ram_rvalid_i) && hit_q |-> resp_o.busy)
        else $error("table bit but not busy");
    a_dir_data_path: assert property (resp_valid_o |->
        (lst_q.tx ? !resp_o.store : !resp_o.tx_data))
        else $error("data against direction");
    a_idle_moves_data: assert property (resp_valid_o && !resp_o.busy |->
        (lst_q.tx ? resp_o.tx_data : resp_o.store))
        else $error("idle moved no data");
    a_busy_tx_quiet: assert property (resp_valid_o && resp_o.busy && lst_q.tx
        && lst_q.sa != 5'h00 && lst_q.sa != 5'h1F |-> !resp_o.tx_data)
        else $error("busy transmit sent data");
    a_bcast_addr: assert property (
        resp_valid_o && resp_o.bcast |-> lst_q.rt_addr == 5'h1F)
        else $error("broadcast on other address");
    a_supersede_cause: assert property (superseded_o |-> own_tx_q)
        else $error("supersede without own transmit");

    // main scenarios
    c_busy_resp: cover property (resp_valid_o && resp_o.busy);
    c_fetch: cover property (ram_rvalid_i && wait_q);
    c_supersede: cover property (superseded_o);
endmodule

bind rbb_busy_bcast_ctrl rbb_chk i_chk (.*);

// File: verif/rbb_ram_model.sv
/*
 * shared-ram responder for busy table reads.
 * assumes: one read in flight; lat_i of 1 answers in the next cycle.
 */
`timescale 1ns/10ps
module rbb_ram_model (
    input  wire logic             clk_i,
    input  wire logic             rd_i,
    input  wire logic [15:0]      addr_i,
    input  wire logic [7:0][15:0] tbl_i,
    input  wire logic [31:0]      lat_i,
    output logic                  rvalid_o,
    output logic [15:0]           rdata_o
);
    int          cnt = 0;
    logic [15:0] word;

    initial begin
        rvalid_o = 1'b0;
        rdata_o  = 16'h5A5A;
    end

    // idle data toggles so a stale word never reads as good
    always @(posedge clk_i) begin
        if (rd_i) begin
            word = (addr_i[15:3] == 13'h0048) ? tbl_i[addr_i[2:0]] : ~rdata_o;
            cnt  = lat_i;
        end
        if (cnt == 1) begin
            rvalid_o <= 1'b1;
            rdata_o  <= word;
        end else begin
            rvalid_o <= 1'b0;
            rdata_o  <= ~rdata_o;
        end
        if (cnt > 0) cnt = cnt - 1;
    end
endmodule

// File: verif/tb.sv
/*
 * self-checking bench for the busy / broadcast decision block.
 * assumes: ram model answers table reads; checker is bound in.
 */
`timescale 1ns/10ps
module tb;
    localparam logic [63:0] CFGS [8] = '{64'h0400_2000_0000_0000, 64'h0000_2000_0000_4000,
        64'h0000_2000_8008_0000, 64'h0000_2000_A008_0000, 64'h0000_2000_8000_4000,
        64'h0410_2000_8020_0000, 64'h0000_2000_8020_0000, 64'h0400_0000_8000_0000};
    localparam logic [10:0] OPS [6] = '{11'h064, 11'h464, 11'h410, 11'h3F1, 11'h7F3, 11'h014};
    localparam logic [4:0]  SAS [4] = '{5'h02, 5'h0F, 5'h13, 5'h1E};
    logic              clk, rstn, reg_wr, reg_rd, cmd_valid, cmd_contig;
    logic [7:0]        reg_addr;
    logic [15:0]       reg_wdata, reg_rdata, ram_addr, ram_rdata, c1, c2, c3, c4, c5;
    logic              ram_rd, ram_rvalid, resp_valid, superseded;
    logic [4:0]        own;
    logic [7:0][15:0]  tbl;
    rbb_pkg::rbb_cmd_t cmd_word;
    rbb_pkg::rbb_dec_t resp;
    int                lat = 1, bad_count = 0, checks = 0;

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    rbb_busy_bcast_ctrl i_dut (.ref_clk_i(clk), .rstn_i(rstn), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .cmd_valid_i(cmd_valid), .cmd_word_i(cmd_word),
        .cmd_contig_i(cmd_contig), .own_rt_addr_i(own), .ram_rd_o(ram_rd),
        .ram_addr_o(ram_addr), .ram_rdata_i(ram_rdata), .ram_rvalid_i(ram_rvalid),
        .resp_valid_o(resp_valid), .resp_o(resp), .superseded_o(superseded));
    rbb_ram_model i_ram (.clk_i(clk), .rd_i(ram_rd), .addr_i(ram_addr), .tbl_i(tbl),
        .lat_i(lat), .rvalid_o(ram_rvalid), .rdata_o(ram_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_dec(input rbb_pkg::rbb_dec_t e, input rbb_pkg::rbb_dec_t g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED decision expected %b seen %b", e, g);
        end
    endtask

    // one-cycle strobes, a clock edge left between accesses
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        cmp16("reg_rdata", e, reg_rdata);
    endtask

    task automatic cfg(input logic [15:0] a1, a2, a3, a4, a5);
        logic [4:0][15:0] v;
        v = {a1, a2, a3, a4, a5};
        {c1, c2, c3, c4, c5} = v;
        for (int k = 0; k < 5; k++) wr(8'(k * 4), v[4 - k]);
    endtask

    // expected decision from the shadow configuration
    function automatic rbb_pkg::rbb_dec_t exp_dec(input logic [4:0] rt, input logic [10:0] op);
        logic              enh, md, bsy, bc;
        rbb_pkg::rbb_dec_t d;
        enh = c3[15];
        bc  = (rt == 5'h1F) && !c5[7];
        md  = (op[9:5] == 5'h00) || (op[9:5] == 5'h1F);
        bsy = (enh && c3[5]) ? c1[4] : (!c1[10] || (enh && !c3[5] && c2[13]
              && tbl[{bc, op[10], op[9]}][op[8:5]]));
        d.bcast   = bc;
        d.busy    = bsy;
        d.store   = !op[10] && (!bsy || !(enh && c3[3]) || (md && op[4:0] != 5'h11)
                    || (md && enh && c3[13]));
        d.tx_data = op[10] && (!bsy || (md && op[4:0] == 5'h10 && enh && c3[13])
                    || (md && op[4:0] == 5'h13 && !(enh && c4[14])));
        return d;
    endfunction

    // one command, bounded wait for its decision
    task automatic cmd(input logic [4:0] rt, input logic [10:0] op, input logic take);
        int   rds = 0;
        logic got = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word  <= {rt, op};
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (int n = 0; n < 12 && !got; n++) begin
            @(negedge clk);
            if (ram_rd === 1'b1) begin
                rds++;
                cmp16("ram_addr", {13'h0048, (rt == 5'h1F) && !c5[7], op[10:9]}, ram_addr);
            end
            if (resp_valid === 1'b1) begin
                got = 1'b1;
                cmp_dec(exp_dec(rt, op), resp);
            end
        end
        cmp16("fetches", {15'h0, take && c3[15] && !c3[5] && c2[13]}, rds[15:0]);
        cmp16("response", {15'h0, take}, {15'h0, got});
        if (take && !got) results();
    endtask

    // broadcast receive, own transmit next cycle
    task automatic pair(input logic ctg, input logic [15:0] e);
        int n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word  <= {5'h1F, 11'h064};
        @(posedge clk);
        cmd_word   <= {own, 11'h464};
        cmd_contig <= ctg;
        @(posedge clk);
        cmd_valid  <= 1'b0;
        cmd_contig <= 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (superseded === 1'b1) n++;
        end
        cmp16("superseded", e, n[15:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rstn, reg_wr, reg_rd, cmd_valid, cmd_contig} = 5'b00000;
        {reg_addr, reg_wdata, cmd_word} = '0;
        {c1, c2, c3, c4, c5} = {16'h0400, 64'h0};
        own = 5'h05;
        tbl = {16'h4008, 16'h0000, 16'h0000, 16'h8004, 16'h4000, 16'h8000, 16'h0008, 16'h0004};
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp16("reset ram_addr", rbb_pkg::LUT_BASE, ram_addr);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(rbb_pkg::CFG1_OFS, rbb_pkg::CFG1_RST);
        for (int k = 1; k < 5; k++) rdc(8'(k * 4), 16'h0000);
        wr(8'h18, 16'hFFFF);
        rdc(8'h18, 16'h0000);
        cfg(16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        cmd(5'h1F, 11'h064, 1'b1);
        rdc(rbb_pkg::STAT_OFS, 16'h0105);
        cmd(5'h07, 11'h064, 1'b0);
        pair(1'b1, 16'h0001);
        pair(1'b0, 16'h0000);
        cfg(16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0080);
        cmd(5'h1F, 11'h064, 1'b0);
        @(posedge clk);
        own <= 5'h1F;
        cmd(5'h1F, 11'h464, 1'b1);
        @(posedge clk);
        own <= 5'h05;
        // busy control and alternate status sources against every data path
        for (int i = 0; i < 8; i++) begin
            cfg(CFGS[i][63:48], CFGS[i][47:32], CFGS[i][31:16], CFGS[i][15:0], 16'h0000);
            for (int j = 0; j < 6; j++) begin
                cmd(own, OPS[j], 1'b1);
            end
        end
        // all eight table words, prompt and slow memory
        cfg(16'h0400, 16'h2000, 16'h8000, 16'h0000, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            lat = i[0] ? 5 : 1;
            cmd(i[3] ? 5'h1F : own, {i[2], SAS[i[1:0]], 5'h01}, 1'b1);
        end
        results();
    end
endmodule
